// [common/ccmc_pkg.sv]
// Shared constants for the context identifier mask control bank
package ccmc_pkg;
    // Register word offsets (byte addresses)
    localparam logic [7:0] CCMC_OFF_LOWER = 8'h00;
    localparam logic [7:0] CCMC_OFF_UPPER = 8'h04;
    localparam logic [7:0] CCMC_OFF_STATUS = 8'h08;
    // Comparator and field geometry
    localparam int CCMC_MAX_CMP = 8;
    localparam int CCMC_MAX_BYTES = 4;
    localparam int CCMC_FIELD_W = 8;
    localparam int CCMC_UPPER_FIRST = 4;
    localparam int CCMC_CTXID_W = 32;
    // Reset values; the documented reset content is unknown, zero is chosen
    localparam logic [7:0] CCMC_MASK_RST = 8'h00;
    localparam logic [31:0] CCMC_RDATA_RST = 32'h0000_0000;
    // Status register field positions
    localparam int CCMC_ST_DROP = 0;
    localparam int CCMC_ST_UPPER_ON = 1;
    localparam int CCMC_ST_COUNT_LSB = 4;
    localparam int CCMC_ST_WIDTH_LSB = 8;
endpackage

// [src/ccmc_cmp.sv]
`timescale 1ns/100ps
// One context identifier comparator with byte-wise masking
module ccmc_cmp
    import ccmc_pkg::*;
#(
    parameter int BYTES = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Comparison inputs
    input wire logic en,
    input wire logic [CCMC_CTXID_W-1:0] ctxid,
    input wire logic [CCMC_CTXID_W-1:0] value,
    input wire logic [CCMC_FIELD_W-1:0] mask,
    // Result
    output logic match_ff
);
    logic [CCMC_MAX_BYTES-1:0] byte_ok;

    // Refuse a byte count that the byte lanes cannot serve
    if (BYTES < 0 || BYTES > CCMC_MAX_BYTES) begin : g_bad_cfg
        $error("ccmc_cmp: byte count out of range");
    end

    // Per byte: a set mask bit drops the byte, bytes beyond the width never count
    for (genvar b = 0; b < CCMC_MAX_BYTES; b++) begin : g_byte
        if (b < BYTES) begin : g_on
            assign byte_ok[b] = mask[b] ||
                (ctxid[b*8 +: 8] == value[b*8 +: 8]);
        end else begin : g_off
            assign byte_ok[b] = 1'b1;
        end
    end

    // Registered match: every unmasked byte equal
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            match_ff <= 1'b0;
        end else begin
            match_ff <= en && (&byte_ok);
        end
    end
endmodule

// [src/ccmc_top.sv]
// Decided for this implementation: the strobed register port and the register offsets.
`timescale 1ns/100ps
// What this block does
// - Mask writes are dropped while trace is enabled or not yet idle.
// - Masked byte with nonzero value gives an unconstrained comparator result.
// - Upper register exists only with over four comparators and nonzero width.
// - Upper register holds one mask field per comparator above four.
// - Field width follows context width; missing bits read zero, ignore writes.
// - Upper register is 32-bit read-write, content unknown after reset; here reset loads zero.
// - Fields for comparators seven to four sit at bytes three to zero.
// - Mask bit n selects value byte n of its comparator.
// - Comparator zero field exists only with at least one comparator.
// - Mask bit zero keeps the byte in the comparison, one drops it.
module ccmc_top
    import ccmc_pkg::*;
#(
    parameter int NUM_CMP = 8,
    parameter int CID_BYTES = 4
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [31:0] reg_rdata,
    // Trace unit state
    input wire logic trace_enabled,
    input wire logic trace_idle,
    // Comparison inputs
    input wire logic [CCMC_CTXID_W-1:0] cur_ctxid,
    input wire logic [CCMC_MAX_CMP*CCMC_CTXID_W-1:0] ctxid_comparator_value,
    // Comparator results
    output logic [CCMC_MAX_CMP-1:0] cmp_match
);
    // Upper register only with more than four comparators and a nonzero width
    localparam bit UPPER_ON = (NUM_CMP > CCMC_UPPER_FIRST) && (CID_BYTES > 0);

    // Elaboration check of the configuration
    // The context identifier has 32 bits, so the context spans at most four bytes
    if (NUM_CMP < 0 || NUM_CMP > CCMC_MAX_CMP || CID_BYTES < 0 ||
        CID_BYTES > CCMC_MAX_BYTES) begin : g_bad_cfg
        $error("ccmc_top: comparator count or context width out of range");
    end

    logic [CCMC_FIELD_W-1:0] mask_ff [CCMC_MAX_CMP];
    logic [CCMC_FIELD_W-1:0] field_imp [CCMC_MAX_CMP];
    logic [CCMC_MAX_CMP-1:0] cmp_en;
    logic [31:0] lower_view;
    logic [31:0] upper_view;
    logic [31:0] status_view;
    logic [31:0] nxt_rdata;
    logic blocked;
    logic wr_lower;
    logic wr_upper;
    logic drop_ff;

    // Writes to mask registers are refused while tracing or not idle
    assign blocked = trace_enabled || !trace_idle;
    assign wr_lower = reg_wr && (reg_addr == CCMC_OFF_LOWER) && !blocked;
    assign wr_upper = reg_wr && (reg_addr == CCMC_OFF_UPPER) && !blocked;

    // Per comparator: implemented mask bits, storage and comparator
    for (genvar k = 0; k < CCMC_MAX_CMP; k++) begin : g_cmp
        // Comparators one to three carry no mask field and always compare in full
        localparam bit FIELD_ON = (k == 0) ? (NUM_CMP >= 1)
            : ((k >= CCMC_UPPER_FIRST) && (k < NUM_CMP) && UPPER_ON);
        localparam logic [CCMC_FIELD_W-1:0] IMP_BITS = FIELD_ON ?
            CCMC_FIELD_W'((1 << CID_BYTES) - 1) : '0;
        // Byte lane in the written word; clamped to zero below comparator four
        // so the unused part-selects of comparators one to three stay in range
        localparam int LANE = (k >= CCMC_UPPER_FIRST) ? (k - CCMC_UPPER_FIRST) : 0;

        assign field_imp[k] = IMP_BITS;
        assign cmp_en[k] = (k < NUM_CMP) && (CID_BYTES > 0);

        // Mask field storage; unimplemented bits stay zero
        // Reset to zero so no stray mask drops a byte before software programs it
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                mask_ff[k] <= CCMC_MASK_RST;
            end else if (k == 0 && wr_lower) begin
                mask_ff[k] <= reg_wdata[LANE*CCMC_FIELD_W +: CCMC_FIELD_W] & IMP_BITS;
            end else if (k >= CCMC_UPPER_FIRST && wr_upper) begin
                mask_ff[k] <= reg_wdata[LANE*CCMC_FIELD_W +: CCMC_FIELD_W] & IMP_BITS;
            end
        end

        ccmc_cmp #(
            .BYTES(CID_BYTES)
        ) u_cmp (
            .ref_clk(ref_clk),
            .rst(rst),
            .en(cmp_en[k]),
            .ctxid(cur_ctxid),
            .value(ctxid_comparator_value[k*CCMC_CTXID_W +: CCMC_CTXID_W]),
            .mask(mask_ff[k]),
            .match_ff(cmp_match[k])
        );
    end

    // Read views of the registers
    assign lower_view = {24'h00_0000, mask_ff[0]};
    assign upper_view = {mask_ff[7], mask_ff[6], mask_ff[5], mask_ff[4]};
    assign status_view = {20'h0_0000, 4'(CID_BYTES), 4'(NUM_CMP),
        2'b00, UPPER_ON, drop_ff};

    // Sticky flag for a refused mask write; write one clears, a new drop wins
    // Status writes are never refused, so software can clear it while tracing
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            drop_ff <= 1'b0;
        end else if (reg_wr && blocked &&
            (reg_addr == CCMC_OFF_LOWER || reg_addr == CCMC_OFF_UPPER)) begin
            drop_ff <= 1'b1;
        end else if (reg_wr && reg_addr == CCMC_OFF_STATUS &&
            reg_wdata[CCMC_ST_DROP]) begin
            drop_ff <= 1'b0;
        end
    end

    // Read mux; unmapped offsets read zero
    // Status stays readable even while mask writes are refused
    always_comb begin
        nxt_rdata = 32'h0000_0000;
        unique case (reg_addr)
            CCMC_OFF_LOWER: nxt_rdata = lower_view;
            CCMC_OFF_UPPER: nxt_rdata = upper_view;
            CCMC_OFF_STATUS: nxt_rdata = status_view;
            default: nxt_rdata = 32'h0000_0000;
        endcase
    end

    // Read data one cycle after the strobe, only in that cycle
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            reg_rdata <= CCMC_RDATA_RST;
        end else if (reg_rd) begin
            reg_rdata <= nxt_rdata;
        end else begin
            reg_rdata <= CCMC_RDATA_RST;
        end
    end

    // Checks
    default clocking ck @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    logic [31:0] upper_imp;
    assign upper_imp = {field_imp[7], field_imp[6], field_imp[5], field_imp[4]};
    logic [31:0] v0;
    logic [31:0] v4;
    logic [31:0] v6;
    logic [31:0] v7;
    // Value words of the comparators that the checks below watch
    assign v0 = ctxid_comparator_value[0 +: 32];
    assign v4 = ctxid_comparator_value[4*32 +: 32];
    assign v6 = ctxid_comparator_value[6*32 +: 32];
    assign v7 = ctxid_comparator_value[7*32 +: 32];

    // Register storage, refusal and read-back
    drop_hold_a: assert property (
        reg_wr && blocked && reg_addr == CCMC_OFF_UPPER && !wr_lower
        |=> upper_view == $past(upper_view) && drop_ff)
        else $error("upper mask changed by a refused write");
    write_take_a: assert property (
        wr_upper |=> upper_view == ($past(reg_wdata) & upper_imp))
        else $error("accepted upper write not stored");
    res_zero_a: assert property (
        (upper_view & ~upper_imp) == 32'h0000_0000 &&
        (lower_view[7:0] & ~field_imp[0]) == 8'h00)
        else $error("unimplemented mask bit reads one");
    absent_a: assert property (
        !UPPER_ON |-> upper_view == 32'h0000_0000)
        else $error("upper register present without support");
    field_count_a: assert property (
        upper_imp == {NUM_CMP > 7 ? field_imp[7] : 8'h00, NUM_CMP > 6 ? field_imp[6] : 8'h00,
            NUM_CMP > 5 ? field_imp[5] : 8'h00, NUM_CMP > 4 ? field_imp[4] : 8'h00})
        else $error("wrong number of upper mask fields");
    read_back_a: assert property (
        reg_rd && reg_addr == CCMC_OFF_UPPER ##1 1'b1 |->
        reg_rdata[31:24] == $past(mask_ff[7]) && reg_rdata[7:0] == $past(mask_ff[4]))
        else $error("upper field placement wrong on read");
    lower_zero_a: assert property (
        NUM_CMP < 1 |-> lower_view == 32'h0000_0000)
        else $error("comparator zero field present without comparators");
    // Comparator outcomes, lower mask storage and refusal, drop flag clearing
    keep_byte_a: assert property (
        cmp_en[0] && !mask_ff[0][0] && cur_ctxid[7:0] != v0[7:0] |=> !cmp_match[0])
        else $error("unmasked differing byte still matched");
    top_byte_a: assert property (
        CID_BYTES == 4 && mask_ff[0][3] && cur_ctxid[23:0] == v0[23:0] |=> cmp_match[0])
        else $error("mask bit three did not drop the top byte");
    cmp4_match_a: assert property (
        cmp_en[4] && cur_ctxid == v4 ##1 1'b1 [*2] |-> $past(cmp_match[4]))
        else $error("equal context did not match on comparator four");
    lower_take_a: assert property (
        wr_lower |=> lower_view[7:0] == ($past(reg_wdata[7:0]) & field_imp[0]))
        else $error("accepted lower write not stored");
    lower_hold_a: assert property (
        reg_wr && blocked && reg_addr == CCMC_OFF_LOWER
        |=> lower_view == $past(lower_view) && drop_ff)
        else $error("lower mask changed by a refused write");
    drop_clear_a: assert property (
        reg_wr && reg_addr == CCMC_OFF_STATUS && reg_wdata[CCMC_ST_DROP] |=> !drop_ff)
        else $error("drop flag not cleared");
    masked_top_a: assert property (
        cmp_en[7] && mask_ff[7][3] && cur_ctxid[23:0] == v7[23:0] |=> cmp_match[7])
        else $error("masked top byte still affected comparator seven");
    cmp6_miss_a: assert property (
        cmp_en[6] && mask_ff[6] == 8'h00 && cur_ctxid != v6 |=> !cmp_match[6])
        else $error("differing context matched on comparator six");

    // Main scenarios
    drop_seen_c: cover property (reg_wr && blocked && reg_addr == CCMC_OFF_UPPER);
    lower_drop_c: cover property (reg_wr && blocked && reg_addr == CCMC_OFF_LOWER);
    upper_set_c: cover property (wr_upper ##1 upper_view != 32'h0000_0000);
    masked_hit_c: cover property (mask_ff[4] != 8'h00 && cmp_match[4]);
    read_upper_c: cover property (reg_rd && reg_addr == CCMC_OFF_UPPER);
endmodule

// [test/test_ctxid_comparator_mask_control.sv]
`timescale 1ns/100ps
// Self-checking bench for the context identifier mask control bank
module test_ctxid_comparator_mask_control;
    import ccmc_pkg::*;
    localparam int NCMP = 8;
    localparam int NB = 4;
    localparam logic [31:0] ST_BASE = (32'h1 << CCMC_ST_UPPER_ON)
        | (32'(NCMP) << CCMC_ST_COUNT_LSB) | (32'(NB) << CCMC_ST_WIDTH_LSB);
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic trace_enabled = 1'b0;
    logic trace_idle = 1'b1;
    logic [31:0] cur_ctxid = 32'h0000_0000;
    logic [255:0] cmp_values = '0;
    logic [7:0] cmp_match;
    logic [31:0] data;
    int n_errors = 0;
    int checks = 0;
    // Device under test with full geometry
    ccmc_top #(.NUM_CMP(NCMP), .CID_BYTES(NB)) ccmc_top_inst (
        .ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .trace_enabled(trace_enabled), .trace_idle(trace_idle), .cur_ctxid(cur_ctxid),
        .ctxid_comparator_value(cmp_values), .cmp_match(cmp_match)
    );
    // 200 MHz clock
    always #2.5 ref_clk = ~ref_clk;
    // Compare and count
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // One-cycle read strobe, data taken in the following cycle
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
    // Reset content, status geometry and unmapped space
    task automatic test_reset_values();
        rd(CCMC_OFF_UPPER, data);
        check("upper after reset", data, {4{CCMC_MASK_RST}});
        rd(8'h0C, data);
        check("unmapped read", data, 32'h0000_0000);
        rd(CCMC_OFF_STATUS, data);
        check("status geometry", data, ST_BASE);
        @(posedge ref_clk);
        #1;
        check("read data released", reg_rdata, 32'h0000_0000);
    endtask
    // Field placement and unimplemented bits
    task automatic test_field_layout();
        wr(CCMC_OFF_UPPER, 32'hFFFF_FFFF);
        rd(CCMC_OFF_UPPER, data);
        check("upper fields", data, 32'h0F0F_0F0F);
        wr(CCMC_OFF_UPPER, 32'h0300_0A50);
        rd(CCMC_OFF_UPPER, data);
        check("upper pattern", data, 32'h0300_0A00);
        wr(CCMC_OFF_LOWER, 32'hFFFF_FFFF);
        rd(CCMC_OFF_LOWER, data);
        check("lower field", data, 32'h0000_000F);
    endtask
    // Writes while tracing or busy are dropped and flagged
    task automatic test_drop();
        @(posedge ref_clk);
        trace_enabled <= 1'b1;
        wr(CCMC_OFF_UPPER, 32'h0000_0001);
        wr(CCMC_OFF_LOWER, 32'h0000_0001);
        trace_enabled <= 1'b0;
        trace_idle <= 1'b0;
        wr(CCMC_OFF_UPPER, 32'h0000_0100);
        trace_idle <= 1'b1;
        rd(CCMC_OFF_UPPER, data);
        check("upper kept", data, 32'h0300_0A00);
        rd(CCMC_OFF_LOWER, data);
        check("lower kept", data, 32'h0000_000F);
        rd(CCMC_OFF_STATUS, data);
        check("drop flag", data, ST_BASE | 32'h1);
        wr(CCMC_OFF_STATUS, 32'h0000_0001);
        rd(CCMC_OFF_STATUS, data);
        check("drop flag cleared", data, ST_BASE);
    endtask
    // Masked bytes leave the comparison, unmasked bytes must equal
    task automatic test_compare();
        wr(CCMC_OFF_LOWER, 32'h0000_0002);
        wr(CCMC_OFF_UPPER, 32'h0800_0400);
        @(posedge ref_clk);
        cur_ctxid <= 32'h1122_3344;
        cmp_values <= {32'h0022_3344, 32'h1100_3344, 32'h1100_3344, 32'h1122_3344,
            32'h1122_3345, 32'h1123_3344, 32'h1122_3344, 32'h1122_0044};
        repeat (2) @(posedge ref_clk);
        #1;
        check("match masked", {24'h0, cmp_match}, 32'h0000_00B3);
        wr(CCMC_OFF_UPPER, 32'h0000_0000);
        repeat (2) @(posedge ref_clk);
        #1;
        check("match unmasked", {24'h0, cmp_match}, 32'h0000_0013);
        @(posedge ref_clk);
        cur_ctxid <= 32'h1122_3345;
        repeat (2) @(posedge ref_clk);
        #1;
        check("match moved", {24'h0, cmp_match}, 32'h0000_0008);
    endtask
    // Counts, then verdict
    task automatic stop_test();
        $display("errors %0d checks %0d", n_errors, checks);
        if (n_errors == 0 && checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (2) @(posedge ref_clk);
        rst <= 1'b0;
        test_reset_values();
        test_field_layout();
        test_drop();
        test_compare();
        stop_test();
    end
    // Watchdog well beyond the roughly 52 cycles the tests need
    initial begin
        #20000;
        n_errors++;
        stop_test();
    end
endmodule
